// ===== verilog/iou_pkg.sv
// Package for the I/O instruction unit: constants, types and helpers
package iou_pkg;
    localparam int          IOU_WORD_W       = 24;
    localparam int          IOU_ADDR_W       = 12;
    localparam int          IOU_NGRP         = 8;
    // Instruction fields
    localparam int          IOU_TAG_LSB      = 12;
    localparam int          IOU_TAG_MSB      = 14;
    // First descriptor word
    localparam int          IOU_D1_ADDR_LSB  = 0;
    localparam int          IOU_D1_CNT_LSB   = 12;
    // Second descriptor word
    localparam int          IOU_D2_SEC_LSB   = 0;
    localparam int          IOU_D2_TRK_LSB   = 7;
    localparam int          IOU_D2_BUF_BIT   = 14;
    localparam int          IOU_D2_ASAP_BIT  = 15;
    localparam int          IOU_D2_HALF_BIT  = 16;
    // AHB-Lite register map (byte addresses)
    localparam logic [7:0]  IOU_REG_INSTR    = 8'h00;
    localparam logic [7:0]  IOU_REG_STATUS   = 8'h04;
    localparam logic [7:0]  IOU_REG_LACC     = 8'h08;
    localparam logic [7:0]  IOU_REG_FULL     = 8'h0C;
    localparam logic [7:0]  IOU_REG_MODE     = 8'h10;
    // Timing at 25 MHz
    localparam int          IOU_CLK_HZ       = 25000000;
    localparam int          IOU_ASAP_US      = 128;
    localparam int          IOU_ASAP_CYC     = IOU_ASAP_US * (IOU_CLK_HZ / 1000000);
    localparam int          IOU_LAT_US       = 8320;
    localparam int          IOU_LAT_CYC      = IOU_LAT_US * (IOU_CLK_HZ / 1000000);
    localparam int          IOU_WORD_US      = 128;
    localparam int          IOU_WORD_CYC     = IOU_WORD_US * (IOU_CLK_HZ / 1000000);

    typedef enum logic [2:0] {
        IOU_OP_SENSE  = 3'b000,
        IOU_OP_SETUP  = 3'b001,
        IOU_OP_STORE  = 3'b010,
        IOU_OP_LOAD   = 3'b011,
        IOU_OP_DRUM_W = 3'b100,
        IOU_OP_DRUM_R = 3'b101
    } iou_op_t;

    typedef struct packed {
        logic [11:0] count;
        logic [11:0] addr;
    } iou_desc1_t;

    typedef struct packed {
        logic [6:0]  unused;
        logic        half;
        logic        asap;
        logic        buf_trk;
        logic [6:0]  track;
        logic [6:0]  sector;
    } iou_desc2_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [11:0] addr;
        logic [23:0] wdata;
    } iou_mem_req_t;

    // Modulo-4096 subtraction of the index value from the address field
    function automatic logic [11:0] iou_ea(input logic [11:0] y, input logic [11:0] xr);
        iou_ea = y - xr;
    endfunction
endpackage

// ===== verilog/iou_ahb_slave.sv
// AHB-Lite slave front end for the I/O instruction unit
`timescale 1ns/1ns
`default_nettype none
module iou_ahb_slave (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    input  wire logic [31:0] rd_word,
    output logic             wr_stb,
    output logic             rd_stb,
    output logic [7:0]       reg_addr,
    output logic [31:0]      wr_data,
    output logic [31:0]      hrdata
);
    import iou_pkg::*;
    logic       wpend_q;
    logic [7:0] addr_q;
    wire        take = hsel && hready && htrans[1];
    assign wr_stb   = wpend_q;
    assign reg_addr = wpend_q ? addr_q : haddr;
    assign wr_data  = hwdata;
    assign rd_stb   = take && !hwrite;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wpend_q <= 1'b0;
            addr_q  <= 8'h00;
            hrdata  <= 32'h0000_0000;
        end else begin
            wpend_q <= take && hwrite;
            addr_q  <= haddr;
            if (take && !hwrite) begin
                hrdata <= rd_word;
            end
        end
    end
endmodule
`default_nettype wire

// ===== verilog/iou_bufreg.sv
// Eight I/O buffer registers with full/empty flags
`timescale 1ns/1ns
`default_nettype none
module iou_bufreg #(
    parameter int N = 8
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic [2:0]  cpu_sel,
    input  wire logic        cpu_load,
    input  wire logic        cpu_store,
    input  wire logic [23:0] cpu_wdata,
    input  wire logic [N-1:0] dev_fill,
    input  wire logic [N-1:0] dev_take,
    input  wire logic [23:0] dev_wdata,
    output logic [23:0]      sel_data,
    output logic             sel_full,
    output logic [N-1:0]     full,
    output logic [23:0]      regs [N]
);
    import iou_pkg::*;
    // Data pins pass two flops, in step with the synchronised fill strobe
    logic [23:0] wd_s1_q;
    logic [23:0] wd_s2_q;
    assign sel_data = regs[cpu_sel];
    assign sel_full = full[cpu_sel];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            full <= '0;
            wd_s1_q <= 24'h000000;
            wd_s2_q <= 24'h000000;
            for (int i = 0; i < N; i++) regs[i] <= 24'h000000;
        end else begin
            wd_s1_q <= dev_wdata;
            wd_s2_q <= wd_s1_q;
            for (int i = 0; i < N; i++) begin
                // fill or load sets, set wins
                if (dev_fill[i] || (cpu_load && cpu_sel == 3'(i))) begin
                    full[i] <= 1'b1;
                end else if (dev_take[i] || (cpu_store && cpu_sel == 3'(i))) begin
                    full[i] <= 1'b0;
                end
                if (cpu_load && cpu_sel == 3'(i)) regs[i] <= cpu_wdata;
                else if (dev_fill[i]) regs[i] <= wd_s2_q;
            end
        end
    end
endmodule
`default_nettype wire

// ===== verilog/iou_top.sv
// I/O instruction unit: setup, sense, buffer transfers, drum transfers
// How it works
// - drum write descriptor: address low, count high
// - second descriptor fetched from operand plus one
// - sector bits 0-6, track bits 7-13
// - bit 14 picks buffer or main track
// - bit 16 picks drum half, sticky
// - bit 15 starts write after 128 us
// - drum read stores words from descriptor address
// - transfer takes 8.32 ms plus 0.128 ms/word
// - setup drives operand onto chosen line group
// - tape setup inhibits priority interrupts
// - store from buffer stalls until filled
// - load to buffer stalls until emptied
// - no indexing of buffer load/store after tape setup
// - sense ANDs status lines into left accumulator
// - tag bits 14-12 pick index register 1-7
// - effective address is field minus index
// - instruction word itself is never changed
// - subtraction wraps at twelve bits
// - eight 24-bit buffer registers
//
// The AHB-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module iou_top #(
    parameter int LAT_CYC  = iou_pkg::IOU_LAT_CYC,
    parameter int WORD_CYC = iou_pkg::IOU_WORD_CYC,
    parameter int ASAP_CYC = iou_pkg::IOU_ASAP_CYC
) (
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                hsel,
    input  wire logic [7:0]          haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic                hready,
    input  wire logic [31:0]         hwdata,
    output logic [31:0]              hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    output iou_pkg::iou_mem_req_t    mem_req,
    input  wire logic                mem_ack,
    input  wire logic [23:0]         mem_rdata,
    output logic [191:0]             output_select_lines,
    input  wire logic [191:0]        input_status_lines,
    input  wire logic [7:0]          dev_fill,
    input  wire logic [7:0]          dev_take,
    input  wire logic [23:0]         dev_wdata,
    output logic [7:0]               io_buffer_full,
    output logic [23:0]              io_buffer_out,
    input  wire logic [2:0]          io_buffer_rd_sel,
    input  wire logic                tape_cmd_in,
    output logic                     irq_inhibit,
    output logic                     drum_busy,
    output logic                     drum_word_stb,
    output logic [23:0]              drum_wdata,
    input  wire logic [23:0]         drum_rdata,
    output iou_pkg::iou_desc2_t      drum_desc,
    output logic                     drum_upper_half,
    output logic                     drum_asap_start
);
    import iou_pkg::*;

    typedef enum logic [3:0] {
        IOU_IDLE  = 4'b0000,
        IOU_XRD   = 4'b0001,
        IOU_OPRD  = 4'b0010,
        IOU_D2RD  = 4'b0011,
        IOU_EXEC  = 4'b0100,
        IOU_STWR  = 4'b0101,
        IOU_DWAIT = 4'b0110,
        IOU_DMEM  = 4'b0111,
        IOU_DGAP  = 4'b1000
    } iou_st_t;

    iou_st_t     st_q;
    logic [23:0] instr_q;
    iou_op_t     op_q;
    logic [2:0]  grp_q;
    logic [11:0] ea_q;
    logic [23:0] opnd_q;
    iou_desc1_t  d1_q;
    logic [23:0] lacc_q;
    logic        tape_q;
    logic        half_q;
    logic [31:0] cnt_q;
    logic [11:0] left_q;
    logic [11:0] mptr_q;
    logic [1:0]  ts_s1_q;
    logic [191:0] sl_s1_q;
    logic [191:0] sl_s2_q;
    logic [7:0]  fill_s1_q;
    logic [7:0]  fill_s2_q;
    logic [7:0]  take_s1_q;
    logic [7:0]  take_s2_q;
    logic [7:0]  fill_d_q;
    logic [7:0]  take_d_q;

    logic        wr_stb;
    logic        rd_stb;
    logic [7:0]  reg_addr;
    logic [31:0] wr_data;
    logic [31:0] rd_word;
    logic [23:0] buf_sel_data;
    logic        buf_sel_full;
    logic [7:0]  buf_full;
    logic [23:0] buf_regs [8];

    // Status, fill, take and tape pins pass two flops; fills/takes become single pulses on rising edge
    wire [7:0] fill_p = fill_s2_q & ~fill_d_q;
    wire [7:0] take_p = take_s2_q & ~take_d_q;
    wire [2:0] tag    = instr_q[IOU_TAG_MSB:IOU_TAG_LSB];
    wire       busy   = (st_q != IOU_IDLE);
    wire       start  = wr_stb && reg_addr == IOU_REG_INSTR && !busy;
    wire       no_idx = tape_q && (op_q == IOU_OP_STORE || op_q == IOU_OP_LOAD);
    wire [11:0] y_fld = instr_q[11:0];
    wire       cpu_load  = st_q == IOU_EXEC && op_q == IOU_OP_LOAD && !buf_sel_full;
    wire       cpu_store = st_q == IOU_STWR && mem_ack;
    wire [23:0] sense_val = sl_s2_q[grp_q*24 +: 24];

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign rd_word   = (reg_addr == IOU_REG_INSTR)  ? {8'h00, instr_q} :
                       (reg_addr == IOU_REG_STATUS) ? {26'h0, irq_inhibit, half_q, drum_busy, busy, tape_q, 1'b0} :
                       (reg_addr == IOU_REG_LACC)   ? {8'h00, lacc_q} :
                       (reg_addr == IOU_REG_FULL)   ? {24'h0, io_buffer_full} :
                       (reg_addr == IOU_REG_MODE)   ? {31'h0, tape_q} : 32'h0000_0000;

    iou_ahb_slave u_bus (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .hsel     (hsel),
        .haddr    (haddr),
        .htrans   (htrans),
        .hwrite   (hwrite),
        .hready   (hready),
        .hwdata   (hwdata),
        .rd_word  (rd_word),
        .wr_stb   (wr_stb),
        .rd_stb   (rd_stb),
        .reg_addr (reg_addr),
        .wr_data  (wr_data),
        .hrdata   (hrdata)
    );

    iou_bufreg #(.N(8)) u_buf (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .cpu_sel   (grp_q),
        .cpu_load  (cpu_load),
        .cpu_store (cpu_store),
        .cpu_wdata (opnd_q),
        .dev_fill  (fill_p),
        .dev_take  (take_p),
        .dev_wdata (dev_wdata),
        .sel_data  (buf_sel_data),
        .sel_full  (buf_sel_full),
        .full      (buf_full),
        .regs      (buf_regs)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sl_s1_q   <= '0;
            sl_s2_q   <= '0;
            fill_s1_q <= 8'h00;
            fill_s2_q <= 8'h00;
            take_s1_q <= 8'h00;
            take_s2_q <= 8'h00;
            fill_d_q  <= 8'h00;
            take_d_q  <= 8'h00;
            ts_s1_q   <= 2'b00;
        end else begin
            sl_s1_q   <= input_status_lines;
            sl_s2_q   <= sl_s1_q;
            fill_s1_q <= dev_fill;
            fill_s2_q <= fill_s1_q;
            take_s1_q <= dev_take;
            take_s2_q <= take_s1_q;
            fill_d_q  <= fill_s2_q;
            take_d_q  <= take_s2_q;
            ts_s1_q   <= {ts_s1_q[0], tape_cmd_in};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q    <= IOU_IDLE;
            instr_q <= 24'h000000;
            op_q    <= IOU_OP_SENSE;
            grp_q   <= 3'h0;
            ea_q    <= 12'h000;
            opnd_q  <= 24'h000000;
            d1_q    <= '0;
            lacc_q  <= 24'h000000;
            tape_q  <= 1'b0;
            half_q  <= 1'b0;
            cnt_q   <= 32'h0;
            left_q  <= 12'h000;
            mptr_q  <= 12'h000;
            mem_req <= '0;
            output_select_lines <= '0;
            io_buffer_full  <= 8'h00;
            io_buffer_out   <= 24'h000000;
            irq_inhibit     <= 1'b0;
            drum_busy       <= 1'b0;
            drum_word_stb   <= 1'b0;
            drum_wdata      <= 24'h000000;
            drum_desc       <= '0;
            drum_upper_half <= 1'b0;
            drum_asap_start <= 1'b0;
        end else begin
            io_buffer_full  <= buf_full;
            io_buffer_out   <= buf_regs[io_buffer_rd_sel];
            irq_inhibit     <= tape_q;
            drum_upper_half <= half_q;
            drum_word_stb   <= 1'b0;
            drum_asap_start <= 1'b0;
            if (wr_stb && reg_addr == IOU_REG_MODE) tape_q <= wr_data[0];
            unique case (st_q)
                IOU_IDLE: begin
                    if (start) begin
                        instr_q <= wr_data[23:0];
                        op_q    <= iou_op_t'(wr_data[29:27]);
                        grp_q   <= wr_data[26:24];
                        st_q    <= IOU_XRD;
                    end
                end
                IOU_XRD: begin
                    if (tag == 3'h0 || no_idx) begin
                        ea_q    <= y_fld;
                        mem_req <= '{req: 1'b1, we: 1'b0, addr: y_fld, wdata: 24'h0};
                        st_q    <= IOU_OPRD;
                    end else if (!mem_req.req) begin
                        mem_req <= '{req: 1'b1, we: 1'b0, addr: {9'h0, tag}, wdata: 24'h0};
                    end else if (mem_ack) begin
                        ea_q    <= iou_ea(y_fld, mem_rdata[11:0]);
                        mem_req <= '{req: 1'b1, we: 1'b0, addr: iou_ea(y_fld, mem_rdata[11:0]), wdata: 24'h0};
                        st_q    <= IOU_OPRD;
                    end
                end
                IOU_OPRD: begin
                    if (mem_ack) begin
                        opnd_q <= mem_rdata;
                        d1_q   <= mem_rdata;
                        if (op_q == IOU_OP_DRUM_W || op_q == IOU_OP_DRUM_R) begin
                            // second word at operand plus one
                            mem_req <= '{req: 1'b1, we: 1'b0, addr: ea_q + 12'h001, wdata: 24'h0};
                            st_q    <= IOU_D2RD;
                        end else begin
                            mem_req <= '0;
                            st_q    <= IOU_EXEC;
                        end
                    end
                end
                IOU_D2RD: begin
                    if (mem_ack) begin
                        mem_req <= '0;
                        // sector, track and track type kept
                        drum_desc <= mem_rdata;
                        half_q    <= mem_rdata[IOU_D2_HALF_BIT];
                        mptr_q    <= d1_q.addr;
                        left_q    <= d1_q.count;
                        drum_busy <= 1'b1;
                        if (op_q == IOU_OP_DRUM_W && mem_rdata[IOU_D2_ASAP_BIT]) begin
                            cnt_q <= 32'(ASAP_CYC);
                            drum_asap_start <= 1'b1;
                        end else begin
                            cnt_q <= 32'(LAT_CYC);
                        end
                        st_q <= IOU_DWAIT;
                    end
                end
                IOU_DWAIT: begin
                    if (left_q == 12'h000) begin
                        drum_busy <= 1'b0;
                        st_q      <= IOU_IDLE;
                    end else if (cnt_q <= 32'h1) begin
                        mem_req <= '{req: 1'b1, we: op_q == IOU_OP_DRUM_R, addr: mptr_q, wdata: drum_rdata};
                        st_q    <= IOU_DMEM;
                    end else begin
                        cnt_q <= cnt_q - 32'h1;
                    end
                end
                IOU_DMEM: begin
                    if (mem_ack) begin
                        mem_req       <= '0;
                        drum_wdata    <= mem_rdata;
                        drum_word_stb <= 1'b1;
                        mptr_q <= mptr_q + 12'h001;
                        left_q <= left_q - 12'h001;
                        cnt_q  <= 32'(WORD_CYC);
                        st_q   <= IOU_DWAIT;
                    end
                end
                IOU_EXEC: begin
                    unique case (op_q)
                        IOU_OP_SETUP: begin
                            // drive selected group, tape mode from pin
                            output_select_lines[grp_q*24 +: 24] <= opnd_q;
                            tape_q <= ts_s1_q[1];
                            st_q   <= IOU_IDLE;
                        end
                        IOU_OP_SENSE: begin
                            lacc_q <= sense_val & opnd_q;
                            st_q   <= IOU_IDLE;
                        end
                        IOU_OP_LOAD: begin
                            if (!buf_sel_full) st_q <= IOU_IDLE;
                        end
                        IOU_OP_STORE: begin
                            if (buf_sel_full) begin
                                mem_req <= '{req: 1'b1, we: 1'b1, addr: ea_q, wdata: buf_sel_data};
                                st_q    <= IOU_STWR;
                            end
                        end
                        default: st_q <= IOU_IDLE;
                    endcase
                end
                IOU_STWR: begin
                    if (mem_ack) begin
                        mem_req <= '0;
                        st_q    <= IOU_IDLE;
                    end
                end
                default: st_q <= IOU_IDLE;
            endcase
        end
    end

    property p_stall_hold;
        @(posedge hclk) disable iff (!hresetn)
        (st_q == IOU_EXEC && op_q == IOU_OP_STORE && !buf_sel_full) |=> (st_q == IOU_EXEC);
    endproperty
    a_stall_hold: assert property (p_stall_hold) else $error("store stall left early");

    property p_load_stall;
        @(posedge hclk) disable iff (!hresetn)
        (st_q == IOU_EXEC && op_q == IOU_OP_LOAD && buf_sel_full) |=> (st_q == IOU_EXEC);
    endproperty
    a_load_stall: assert property (p_load_stall) else $error("load overwrote full buffer");

    property p_sense;
        @(posedge hclk) disable iff (!hresetn)
        (st_q == IOU_EXEC && op_q == IOU_OP_SENSE) |=> (lacc_q == ($past(sense_val) & $past(opnd_q)));
    endproperty
    a_sense: assert property (p_sense) else $error("sense result wrong");

    property p_setup;
        @(posedge hclk) disable iff (!hresetn)
        (st_q == IOU_EXEC && op_q == IOU_OP_SETUP) |=> (output_select_lines[$past(grp_q)*24 +: 24] == $past(opnd_q));
    endproperty
    a_setup: assert property (p_setup) else $error("setup lines wrong");

    property p_inhibit;
        @(posedge hclk) disable iff (!hresetn)
        tape_q |=> irq_inhibit;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("interrupts not inhibited");

    property p_ea;
        @(posedge hclk) disable iff (!hresetn)
        (st_q == IOU_XRD && mem_req.req && mem_ack && tag != 3'h0 && !no_idx)
            |=> (ea_q == 12'($past(y_fld) - $past(mem_rdata[11:0])));
    endproperty
    a_ea: assert property (p_ea) else $error("effective address wrong");

    property p_noidx;
        @(posedge hclk) disable iff (!hresetn)
        (st_q == IOU_XRD && (tag == 3'h0 || no_idx)) |=> (ea_q == $past(y_fld));
    endproperty
    a_noidx: assert property (p_noidx) else $error("address modified wrongly");

    property p_d2addr;
        @(posedge hclk) disable iff (!hresetn)
        (st_q == IOU_OPRD && mem_ack && (op_q == IOU_OP_DRUM_W || op_q == IOU_OP_DRUM_R))
            |=> (mem_req.addr == 12'(ea_q + 12'h001));
    endproperty
    a_d2addr: assert property (p_d2addr) else $error("second descriptor address wrong");

    property p_half;
        @(posedge hclk) disable iff (!hresetn)
        (st_q == IOU_D2RD && mem_ack) |=> (half_q == $past(mem_rdata[IOU_D2_HALF_BIT]));
    endproperty
    a_half: assert property (p_half) else $error("drum half not latched");
endmodule
`default_nettype wire

// ===== tb/iou_mem_model.sv
// Core memory model answering the unit's word requests
`timescale 1ns/1ns
`default_nettype none
module iou_mem_model (
    input  wire iou_pkg::iou_mem_req_t mem_req,
    input  wire logic                  hclk,
    output logic                       mem_ack,
    output logic [23:0]                mem_rdata
);
    import iou_pkg::*;
    logic [23:0] mem [4096];
    logic [1:0]  wait_q = 2'h0;
    initial mem_ack = 1'b0;
    // Wait count mixes prompt and slow answers
    always @(posedge hclk) begin
        mem_ack <= 1'b0;
        if (mem_req.req && !mem_ack) begin
            wait_q <= wait_q + 2'h1;
            if (wait_q != 2'h0) begin
                mem_ack <= 1'b1;
                if (mem_req.we) mem[mem_req.addr] <= mem_req.wdata;
            end
        end
    end
    // Outside an answer the data bus shows a changed word, never a stale one
    assign mem_rdata = mem_ack ? mem[mem_req.addr] : ~mem[mem_req.addr];
endmodule
`default_nettype wire

// ===== tb/iou_top_tb.sv
// Self-checking bench for the I/O instruction unit
`timescale 1ns/1ns
`default_nettype none
module iou_top_tb;
    import iou_pkg::*;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, mem_ack;
    logic [1:0] htrans = 2'h0;
    logic [7:0] haddr = 8'h00, full, dev_take = 8'h00, dev_fill = 8'h00;
    logic tcmd = 1'b0, irq, uhalf, dbusy;
    logic [31:0] hwdata = 32'h0, hrdata, rd, rd_val, lfsr = 32'h4E5CD798;
    logic [191:0] osl, isl = 192'h0;
    logic [23:0] mem_rdata, bout, x, dwd = 24'h0, drd = 24'h0;
    logic [2:0] rsel = 3'h0;
    iou_mem_req_t mem_req;
    iou_desc2_t ddesc;
    logic [31:0] exp_q[$];
    string nm;
    event rd_ev;
    int error_cnt = 0, num_checks = 0, cyc = 0;
    always #20 hclk = ~hclk;
    iou_top #(.LAT_CYC(20), .WORD_CYC(4), .ASAP_CYC(4)) DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(), .mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .output_select_lines(osl), .input_status_lines(isl), .dev_fill(dev_fill), .dev_take(dev_take),
        .dev_wdata(dwd), .io_buffer_full(full), .io_buffer_out(bout), .io_buffer_rd_sel(rsel),
        .tape_cmd_in(tcmd), .irq_inhibit(irq), .drum_busy(dbusy), .drum_word_stb(), .drum_wdata(),
        .drum_rdata(drd), .drum_desc(ddesc), .drum_upper_half(uhalf), .drum_asap_start());
    iou_mem_model P (.mem_req(mem_req), .hclk(hclk), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // Busy is polled, never a fixed wait, because stalls vary
    task automatic exec(input iou_op_t op, input logic [2:0] g, input logic [23:0] ins);
        ahb(1'b1, IOU_REG_INSTR, {2'h0, op, g, ins});
        do ahb(1'b0, IOU_REG_STATUS, 32'h0); while (rd[2] !== 1'b0);
    endtask
    task automatic seen(input string n, input logic [31:0] v);
        nm = n;
        rd_val = v;
        ->rd_ev;
        #1;
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] v, input logic [31:0] e);
        num_checks++;
        if (v !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", n, e, v);
        end
    endtask
    always @(rd_ev) chk(nm, rd_val, exp_q.pop_front());
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            print_verdict();
        end
    end
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        // every group and tag, index of both signs
        for (int g = 0; g < 8; g++) begin
            x = g[0] ? 24'hFFF - 24'(g) : 24'(g * 3);
            P.mem[g] = x;
            lfsr = nxt(lfsr);
            P.mem[12'h400 - x[11:0]] = lfsr[23:0];
            exp_q.push_back({8'h0, lfsr[23:0]});
            exec(IOU_OP_SETUP, 3'(g), {9'h0, 3'(g), 12'h400});
            seen("select lines", {8'h0, osl[g*24+:24]});
        end
        // status lines masked into the left accumulator
        @(posedge hclk) isl <= {6{lfsr}};
        P.mem[12'h050] = lfsr[31:8];
        exec(IOU_OP_SENSE, 3'h5, 24'h050);
        ahb(1'b0, IOU_REG_LACC, 32'h0);
        exp_q.push_back({8'h0, isl[143:120] & lfsr[31:8]});
        seen("left acc", rd);
        // second load waits until the device takes
        rsel <= 3'h3;
        P.mem[12'h060] = 24'h123456;
        P.mem[12'h061] = 24'hABCDEF;
        exec(IOU_OP_LOAD, 3'h3, 24'h060);
        ahb(1'b1, IOU_REG_INSTR, {2'h0, IOU_OP_LOAD, 3'h3, 24'h061});
        repeat (30) @(posedge hclk);
        exp_q.push_back(32'h123456);
        seen("stalled buffer", {8'h0, bout});
        @(posedge hclk) dev_take <= 8'h08;
        do ahb(1'b0, IOU_REG_STATUS, 32'h0); while (rd[2] !== 1'b0);
        exp_q.push_back(32'hABCDEF);
        seen("loaded buffer", {8'h0, bout});
        // store empties the buffer into memory
        exec(IOU_OP_STORE, 3'h3, 24'h070);
        exp_q.push_back(32'hABCDEF);
        seen("stored word", {8'h0, P.mem[12'h070]});
        exp_q.push_back(32'h0);
        seen("full flags", {24'h0, full});
        // tape setup before a load to buffer zero, no indexing
        @(posedge hclk) tcmd <= 1'b1;
        rsel <= 3'h0;
        lfsr = nxt(lfsr);
        P.mem[12'h090] = lfsr[23:0];
        exec(IOU_OP_SETUP, 3'h0, 24'h000400);
        exec(IOU_OP_LOAD, 3'h0, 24'h001090);
        exp_q.push_back({8'h0, lfsr[23:0]});
        seen("tape load", {8'h0, bout});
        exp_q.push_back(32'h1);
        seen("irq inhibit", {31'h0, irq});
        // store waits for the device to refill buffer zero
        @(posedge hclk) dev_take <= 8'h09;
        ahb(1'b1, IOU_REG_INSTR, {2'h0, IOU_OP_STORE, 3'h0, 24'h0010A0});
        repeat (10) @(posedge hclk);
        dwd <= ~lfsr[23:0];
        dev_fill <= 8'h01;
        do ahb(1'b0, IOU_REG_STATUS, 32'h0); while (rd[2] !== 1'b0);
        exp_q.push_back({8'h0, ~lfsr[23:0]});
        seen("tape store", {8'h0, P.mem[12'h0A0]});
        // two-word drum read into core memory
        P.mem[12'h0B0] = 24'h0020C0;
        P.mem[12'h0B1] = 24'h014285;
        @(posedge hclk) drd <= lfsr[31:8];
        exec(IOU_OP_DRUM_R, 3'h0, 24'h0000B0);
        exp_q.push_back({8'h0, lfsr[31:8]});
        seen("drum word 0", {8'h0, P.mem[12'h0C0]});
        exp_q.push_back({8'h0, lfsr[31:8]});
        seen("drum word 1", {8'h0, P.mem[12'h0C1]});
        exp_q.push_back(32'h14285);
        seen("drum descriptor", {8'h0, ddesc});
        exp_q.push_back(32'h2);
        seen("drum half, busy", {30'h0, uhalf, dbusy});
        print_verdict();
    end
endmodule
`default_nettype wire
